/* File: osm_top.v */
// optical module control, status and two-wire memory slave
//
// Summary of operation
// R01: transmitter output off while transmit-off pin high, normal while low.
// R02: host sets soft transmit-off at bit 6 of diagnostic byte 110.
// R03: bit 7 of byte 110 shows the transmit-off pin state.
// R04: transmitter disabled when pin or soft bit is set.
// R05: undriven transmit-off pin counts as asserted; host drives low to send.
// R06: cycling the transmit-off pin high then low clears the fault state.
// R07: catastrophic laser fault raises fault output and turns laser off.
// R08: fault output low in normal operation, high on fault.
// R09: fault output latched until transmit-off toggles or power cycles.
// R10: bit 2 of byte 110 shows the transmitter fault.
// R11: 256-byte identification memory at two-wire address 0xa0.
// R12: 256-byte diagnostic memory at two-wire address 0xa2.
// R13: live bias, power, supply, temperature, receive power in diagnostics.
// R14: transmit-off and signal loss states mirrored into diagnostic memory.
// R15: signal loss output high on lost light, mirrored at byte 110 bit 1.
// R16: status bits of byte 110 are read-only, host writes ignored.
`include "osm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module osm_top (
   // clock and reset
   input  wire        clk_i,
   input  wire        sys_rst_i,
   // host control pins
   input  wire        tx_disable_i,
   output wire        tx_fault_o,
   output wire        signal_loss_output_o,
   // two-wire management bus
   input  wire        scl_i,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_o,
   // optical front end
   input  wire        laser_fault_i,
   input  wire        light_loss_i,
   output wire        laser_en_o,
   // monitor words from the converters, same clock
   input  wire [15:0] mon_temp_i,
   input  wire [15:0] mon_vcc_i,
   input  wire [15:0] mon_bias_i,
   input  wire [15:0] mon_txpwr_i,
   input  wire [15:0] mon_rxpwr_i
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   wire [4:0] async_in;
   reg  [4:0] sync1;
   reg  [4:0] sync2;

   assign async_in = {laser_fault_i, light_loss_i, tx_disable_i,
                      sda_i, scl_i};

   localparam [4:0] SYNC_RST = `OSM_SYNC_RST;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_sync
         // tx off resets high so the laser stays dark until driven low
         always @(posedge clk_i) begin
            if (sys_rst_i) begin
               sync1[g] <= SYNC_RST[g]; // R05
               sync2[g] <= SYNC_RST[g];
            end else begin
               sync1[g] <= async_in[g];
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate

   wire scl_s    = sync2[0];
   wire sda_s    = sync2[1];
   wire txdis_s  = sync2[2];
   wire loss_s   = sync2[3];
   wire fault_s  = sync2[4];

   // ------------------------------------------------------------------
   // transmitter control
   // ------------------------------------------------------------------
   reg  soft_dis;
   wire fault_latched;

   osm_tx_ctl u_tx_ctl (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .hw_dis_i    (txdis_s),
      .soft_dis_i  (soft_dis),
      .fault_det_i (fault_s),
      .laser_en_o  (laser_en_o),
      .fault_o     (fault_latched)
   );

   assign tx_fault_o           = fault_latched; // R08 R09
   assign signal_loss_output_o = loss_s;        // R15

   // ------------------------------------------------------------------
   // diagnostic status byte and monitor overlay
   // ------------------------------------------------------------------
   reg  [7:0] csb;

   always @* begin
      csb = 8'h00;
      csb[`OSM_CSB_TXDIS_BIT] = txdis_s;       // R03 R14
      csb[`OSM_CSB_SOFT_BIT]  = soft_dis;      // R02
      csb[`OSM_CSB_FAULT_BIT] = fault_latched; // R10
      csb[`OSM_CSB_LOSS_BIT]  = loss_s;        // R14 R15
   end

   wire [79:0] mon_all = {mon_temp_i, mon_vcc_i, mon_bias_i,
                          mon_txpwr_i, mon_rxpwr_i};

   // ------------------------------------------------------------------
   // memories and address pointers
   // ------------------------------------------------------------------
   reg  [7:0] id_mem [0:255];
   reg  [7:0] dg_mem [0:255];
   reg  [7:0] ptr_id;
   reg  [7:0] ptr_dg;
   reg        bank_dg;

   wire [7:0] cur_ptr   = bank_dg ? ptr_dg : ptr_id;
   wire       mon_hit   = (ptr_dg[7:4] == `OSM_MON_HI_NIBBLE) &&
                          (ptr_dg[3:0] <= `OSM_MON_LAST_LO);
   wire [3:0] mon_sel   = `OSM_MON_LAST_LO - ptr_dg[3:0];
   wire [7:0] mon_byte  = mon_all[{mon_sel, 3'b000} +: 8];

   reg  [7:0] rd_byte;

   always @* begin
      rd_byte = 8'h00;
      if (!bank_dg)
         rd_byte = id_mem[ptr_id]; // R11
      else if (ptr_dg == `OSM_CSB_OFFSET)
         rd_byte = csb; // R16
      else if (mon_hit)
         rd_byte = mon_byte; // R13
      else
         rd_byte = dg_mem[ptr_dg]; // R12
   end

   // ------------------------------------------------------------------
   // two-wire slave engine
   // ------------------------------------------------------------------
   localparam [2:0] ST_IDLE      = `OSM_ST_IDLE;
   localparam [2:0] ST_ADDR      = `OSM_ST_ADDR;
   localparam [2:0] ST_ADDR_ACK  = `OSM_ST_ADDR_ACK;
   localparam [2:0] ST_WRITE     = `OSM_ST_WRITE;
   localparam [2:0] ST_WRITE_ACK = `OSM_ST_WRITE_ACK;
   localparam [2:0] ST_READ      = `OSM_ST_READ;
   localparam [2:0] ST_READ_ACK  = `OSM_ST_READ_ACK;

   reg  [2:0] state;
   reg  [3:0] bitcnt;
   reg  [7:0] sr;
   reg  [7:0] txb;
   reg        rw;
   reg        first_byte;
   reg        host_nack;
   reg        sda_oe;
   reg        scl_q;
   reg        sda_q;
   integer    i;

   // edge detection works on the second synchroniser stage only
   wire scl_rise  = scl_s & ~scl_q;
   wire scl_fall  = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         state      <= ST_IDLE;
         bitcnt     <= 4'h0;
         sr         <= 8'h00;
         txb        <= 8'hff;
         rw         <= 1'b0;
         first_byte <= 1'b0;
         host_nack  <= 1'b1;
         sda_oe     <= 1'b0;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         bank_dg    <= 1'b0;
         ptr_id     <= 8'h00;
         ptr_dg     <= 8'h00;
         soft_dis   <= `OSM_SOFT_RST;
         for (i = 0; i < 256; i = i + 1) begin
            id_mem[i] <= 8'h00;
            dg_mem[i] <= 8'h00;
         end
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         if (start_det) begin
            // a repeated start also lands here, keeping the pointers
            state  <= ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_det) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            case (state)
               ST_ADDR, ST_WRITE: begin
                  sr     <= {sr[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end
               ST_READ: begin
                  txb    <= {txb[6:0], 1'b1};
                  bitcnt <= bitcnt + 4'h1;
               end
               ST_READ_ACK: begin
                  host_nack <= sda_s;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state)
               ST_ADDR: begin
                  if (bitcnt == 4'h8) begin
                     if (sr[7:1] == `OSM_DEV_ID ||
                         sr[7:1] == `OSM_DEV_DIAG) begin // R11 R12
                        bank_dg <= (sr[7:1] == `OSM_DEV_DIAG);
                        rw      <= sr[0];
                        sda_oe  <= 1'b1;
                        state   <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  bitcnt <= 4'h0;
                  if (rw) begin
                     txb    <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     state  <= ST_READ;
                  end else begin
                     sda_oe     <= 1'b0;
                     first_byte <= 1'b1;
                     state      <= ST_WRITE;
                  end
               end
               ST_WRITE: begin
                  if (bitcnt == 4'h8) begin
                     sda_oe     <= 1'b1;
                     first_byte <= 1'b0;
                     state      <= ST_WRITE_ACK;
                     if (first_byte) begin
                        if (bank_dg)
                           ptr_dg <= sr;
                        else
                           ptr_id <= sr;
                     end else if (!bank_dg) begin
                        id_mem[ptr_id] <= sr;
                        ptr_id         <= ptr_id + 8'h01;
                     end else begin
                        // only the soft bit of the status byte is writable
                        if (ptr_dg == `OSM_CSB_OFFSET)
                           soft_dis <= sr[`OSM_CSB_SOFT_BIT]; // R02 R16
                        else
                           dg_mem[ptr_dg] <= sr;
                        ptr_dg <= ptr_dg + 8'h01;
                     end
                  end
               end
               ST_WRITE_ACK: begin
                  sda_oe <= 1'b0;
                  bitcnt <= 4'h0;
                  state  <= ST_WRITE;
               end
               ST_READ: begin
                  if (bitcnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     state  <= ST_READ_ACK;
                     if (bank_dg)
                        ptr_dg <= ptr_dg + 8'h01;
                     else
                        ptr_id <= ptr_id + 8'h01;
                  end else begin
                     sda_oe <= ~txb[7];
                  end
               end
               ST_READ_ACK: begin
                  if (!host_nack) begin
                     txb    <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     bitcnt <= 4'h0;
                     state  <= ST_READ;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // open drain: the line is only ever pulled low
   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_oe;

endmodule

`default_nettype wire

/* File: osm_defines.vh */
// constants for the optical module control and status logic
`ifndef OSM_DEFINES_VH
`define OSM_DEFINES_VH

// two-wire device addresses, 7-bit form (0xa0 and 0xa2 as 8-bit bytes)
`define OSM_DEV_ID          7'h50
`define OSM_DEV_DIAG        7'h51

// control/status byte in the diagnostic area
`define OSM_CSB_OFFSET      8'h6e
`define OSM_CSB_TXDIS_BIT   7
`define OSM_CSB_SOFT_BIT    6
`define OSM_CSB_FAULT_BIT   2
`define OSM_CSB_LOSS_BIT    1
`define OSM_SOFT_RST        1'b0

// monitor words, big endian, 0x60 .. 0x69 in the diagnostic area
`define OSM_MON_HI_NIBBLE   4'h6
`define OSM_MON_LAST_LO     4'h9

// synchroniser reset levels: {fault, light loss, tx off, sda, scl}
`define OSM_SYNC_RST        5'b01111

// two-wire engine states
`define OSM_ST_IDLE         3'h0
`define OSM_ST_ADDR         3'h1
`define OSM_ST_ADDR_ACK     3'h2
`define OSM_ST_WRITE        3'h3
`define OSM_ST_WRITE_ACK    3'h4
`define OSM_ST_READ         3'h5
`define OSM_ST_READ_ACK     3'h6

`endif

/* File: osm_tx_ctl.v */
// transmitter enable and latched laser fault
`timescale 1ns/1ps
`default_nettype none

module osm_tx_ctl (
   // clock and reset
   input  wire clk_i,
   input  wire sys_rst_i,
   // synchronised controls
   input  wire hw_dis_i,
   input  wire soft_dis_i,
   input  wire fault_det_i,
   // results
   output wire laser_en_o,
   output wire fault_o
);

   reg  hw_dis_q;
   reg  fault;
   reg  laser_en;

   // a full high-then-low cycle of the pin clears the latch
   wire cycle_done = hw_dis_q & ~hw_dis_i;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         hw_dis_q <= 1'b1;
         fault    <= 1'b0;
         laser_en <= 1'b0;
      end else begin
         hw_dis_q <= hw_dis_i;
         // a fault present during the clearing edge keeps the latch set
         if (fault_det_i)
            fault <= 1'b1; // R07 R09
         else if (cycle_done)
            fault <= 1'b0; // R06 R09
         // pin and soft bit are or'd, fault also forces the laser off
         laser_en <= ~(hw_dis_i | soft_dis_i |
                       fault | fault_det_i); // R01 R04 R07
      end
   end

   assign laser_en_o = laser_en;
   assign fault_o    = fault; // R08

endmodule

`default_nettype wire

/* File: osm_top_assertions.sv */
// checker for transmitter control, fault latch and bus timing
`timescale 1ns/1ps
`default_nettype none
module osm_top_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // pins
   input wire logic tx_disable_i,
   input wire logic tx_fault_o,
   input wire logic laser_fault_i,
   input wire logic light_loss_i,
   input wire logic laser_en_o,
   input wire logic signal_loss_output_o,
   input wire logic scl_i,
   input wire logic sda_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // pin held high then low long enough to pass the synchroniser
   sequence s_toggle;
      tx_disable_i [*3] ##1 (!tx_disable_i && !laser_fault_i) [*5];
   endsequence
   sequence s_pin_low;
      (!tx_disable_i) [*5];
   endsequence
   property p_dis_off;
      tx_disable_i [*4] |-> !laser_en_o;
   endproperty
   property p_fault_set;
      laser_fault_i [*4] |-> tx_fault_o && !laser_en_o;
   endproperty
   property p_fault_quiet;
      (!laser_fault_i) [*5] ##0 !tx_fault_o |=> !tx_fault_o;
   endproperty
   property p_fault_hold;
      s_pin_low ##0 tx_fault_o |=> tx_fault_o;
   endproperty
   property p_fault_clear;
      s_toggle |-> !tx_fault_o;
   endproperty
   property p_loss_hi;
      light_loss_i [*4] |-> signal_loss_output_o;
   endproperty
   property p_loss_lo;
      (!light_loss_i) [*4] |-> !signal_loss_output_o;
   endproperty
   // the slave may only move sda while scl is low
   property p_sda_edge;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_dis_off: assert property (p_dis_off) else $error("laser on");
   a_fault_set: assert property (p_fault_set) else $error("no fault");
   a_fault_quiet: assert property (p_fault_quiet) else $error("fault");
   a_fault_hold: assert property (p_fault_hold) else $error("lost");
   a_fault_clear: assert property (p_fault_clear) else $error("kept");
   a_loss_hi: assert property (p_loss_hi) else $error("loss low");
   a_loss_lo: assert property (p_loss_lo) else $error("loss high");
   a_sda_edge: assert property (p_sda_edge) else $error("sda");
endmodule
bind osm_top osm_top_chk u_chk (
   .clk_i               (clk_i),
   .sys_rst_i           (sys_rst_i),
   .tx_disable_i        (tx_disable_i),
   .tx_fault_o          (tx_fault_o),
   .laser_fault_i       (laser_fault_i),
   .light_loss_i        (light_loss_i),
   .laser_en_o          (laser_en_o),
   .signal_loss_output_o(signal_loss_output_o),
   .scl_i               (scl_i),
   .sda_oe_o            (sda_oe_o)
);
`default_nettype wire

/* File: osm_host_model.sv */
// host board controller model on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module osm_host_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // sda moves mid low phase so it never races the scl edge
   task automatic bit_io(input logic b, output logic r);
      wt(5);
      sda_low_o = !b;
      wt(5);
      scl_o = 1'b1;
      wt(10);
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic start();
      wt(5);
      sda_low_o = 1'b0;
      wt(5);
      scl_o = 1'b1;
      wt(10);
      sda_low_o = 1'b1;
      wt(10);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      wt(5);
      sda_low_o = 1'b1;
      wt(5);
      scl_o = 1'b1;
      wt(10);
      sda_low_o = 1'b0;
      wt(10);
   endtask
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(m, a);
   endtask
endmodule
`default_nettype wire

/* File: tb_osm_top.sv */
// testbench for the optical module control and status block
`include "osm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("FAIL at %0t: got %h exp %h", $time, a, e); end end
module tb_osm_top;
   logic        clk_i, sys_rst_i, tx_en, tx_val, laser_fault_i, light_loss_i;
   logic        scl, sda_low, sda_o, sda_oe_o, tx_fault_o, loss_o, laser_en_o;
   logic [15:0] mv [5];
   logic [7:0]  d;
   logic [4:0]  a2;
   int          n_mismatch, comparisons;
   tri1         tx_w;
   wire         sda_w;
   // undriven pin floats high through the pull-up
   assign tx_w = tx_en ? tx_val : 1'bz;
   assign sda_w = !(sda_low || sda_oe_o);
   osm_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
                        .sda_low_o(sda_low));
   osm_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_disable_i(tx_w),
      .tx_fault_o(tx_fault_o), .signal_loss_output_o(loss_o), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .laser_fault_i(laser_fault_i), .light_loss_i(light_loss_i),
      .laser_en_o(laser_en_o), .mon_temp_i(mv[0]), .mon_vcc_i(mv[1]),
      .mon_bias_i(mv[2]), .mon_txpwr_i(mv[3]), .mon_rxpwr_i(mv[4]));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = !clk_i;
   end
   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task wr(input logic [6:0] dv, input logic [7:0] p, input logic [7:0] v);
      logic [7:0] q;
      logic [2:0] a;
      host.start();
      host.xfer({dv, 1'b0}, 1'b1, q, a[0]);
      host.xfer(p, 1'b1, q, a[1]);
      host.xfer(v, 1'b1, q, a[2]);
      host.stop();
      `CHK(a, 3'b000);
   endtask
   task rd(input logic [6:0] dv, input logic [7:0] p, output logic [7:0] v);
      logic [7:0] q;
      logic [3:0] a;
      host.start();
      host.xfer({dv, 1'b0}, 1'b1, q, a[0]);
      host.xfer(p, 1'b1, q, a[1]);
      host.start();
      host.xfer({dv, 1'b1}, 1'b1, q, a[2]);
      host.xfer(8'hff, 1'b1, v, a[3]);
      host.stop();
      `CHK(a, 4'b1000);
   endtask
   task csb(input logic [7:0] e);
      rd(`OSM_DEV_DIAG, `OSM_CSB_OFFSET, d);
      `CHK(d, e);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      $display("FAIL at %0t: watchdog expired", $time);
      wrap_up;
   end
   initial begin
      sys_rst_i = 1'b1;
      {tx_en, tx_val, laser_fault_i, light_loss_i} = 4'h0;
      mv = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3};
      n_mismatch = 0;
      comparisons = 0;
      cyc(5);
      sys_rst_i = 1'b0;
      cyc(20);
      `CHK(laser_en_o, 1'b0);
      `CHK(tx_fault_o, 1'b0);
      tx_en = 1'b1;
      cyc(5);
      `CHK(laser_en_o, 1'b1);
      $display("test pin done");
      // every bit written, only the soft bit may stick
      wr(`OSM_DEV_DIAG, `OSM_CSB_OFFSET, 8'hff);
      `CHK(laser_en_o, 1'b0);
      csb(8'h40);
      wr(`OSM_DEV_DIAG, `OSM_CSB_OFFSET, 8'h00);
      `CHK(laser_en_o, 1'b1);
      tx_val = 1'b1;
      cyc(5);
      `CHK(laser_en_o, 1'b0);
      csb(8'h80);
      tx_val = 1'b0;
      light_loss_i = 1'b1;
      cyc(5);
      `CHK(loss_o, 1'b1);
      csb(8'h02);
      light_loss_i = 1'b0;
      $display("test status done");
      laser_fault_i = 1'b1;
      cyc(5);
      laser_fault_i = 1'b0;
      cyc(5);
      `CHK(tx_fault_o, 1'b1);
      `CHK(laser_en_o, 1'b0);
      csb(8'h04);
      // soft cycling must not clear the latch
      wr(`OSM_DEV_DIAG, `OSM_CSB_OFFSET, 8'h40);
      wr(`OSM_DEV_DIAG, `OSM_CSB_OFFSET, 8'h00);
      `CHK(tx_fault_o, 1'b1);
      tx_val = 1'b1;
      cyc(5);
      tx_val = 1'b0;
      cyc(6);
      `CHK(tx_fault_o, 1'b0);
      `CHK(laser_en_o, 1'b1);
      $display("test fault done");
      for (int i = 0; i < 10; i++) begin
         rd(`OSM_DEV_DIAG, 8'(8'h60 + i), d);
         `CHK(d, i % 2 ? mv[i / 2][7:0] : mv[i / 2][15:8]);
      end
      wr(`OSM_DEV_ID, 8'h05, 8'h5a);
      wr(`OSM_DEV_DIAG, 8'h05, 8'ha5);
      rd(`OSM_DEV_ID, 8'h05, d);
      `CHK(d, 8'h5a);
      rd(`OSM_DEV_DIAG, 8'h05, d);
      `CHK(d, 8'ha5);
      host.start();
      host.xfer({7'h52, 1'b0}, 1'b1, d, a2[0]);
      host.stop();
      `CHK(a2[0], 1'b1);
      // burst write then burst read: the pointer steps after every byte
      host.start();
      host.xfer({`OSM_DEV_ID, 1'b0}, 1'b1, d, a2[0]);
      host.xfer(8'h06, 1'b1, d, a2[1]);
      host.xfer(8'h3c, 1'b1, d, a2[2]);
      host.xfer(8'hc3, 1'b1, d, a2[3]);
      host.stop();
      `CHK(a2[3:0], 4'h0);
      host.start();
      host.xfer({`OSM_DEV_ID, 1'b0}, 1'b1, d, a2[0]);
      host.xfer(8'h05, 1'b1, d, a2[1]);
      host.start();
      host.xfer({`OSM_DEV_ID, 1'b1}, 1'b1, d, a2[2]);
      host.xfer(8'hff, 1'b0, d, a2[3]);
      `CHK(d, 8'h5a);
      host.xfer(8'hff, 1'b0, d, a2[4]);
      `CHK(d, 8'h3c);
      host.xfer(8'hff, 1'b1, d, a2[4]);
      host.stop();
      `CHK(d, 8'hc3);
      `CHK(a2, 5'b10000);
      // the data pin only ever pulls low, through its enable
      `CHK(sda_o, 1'b0);
      $display("test memory done");
      wrap_up;
   end
endmodule
`default_nettype wire
